// ### sub_exec_pkg.sv
/*
  Constants shared by the subtract execution unit: opcode fields, address
  resolution, register offsets and encodings of phase and instruction kind.
  Assumes one synchronous clock domain; the decoder and data memory run on it.
*/
// What this block does
// - literal form: literal minus working register into working register
// - literal form: one word, one cycle: decode, read, compute, write
// - file form: file register minus working register, two's complement
// - dest bit zero: difference to working register, file unchanged
// - dest bit one: difference written back to addressed file register
// - access bit zero: file address in access bank, bank select ignored
// - access bit one: address resolved in the bank held by bank select
// - file form: one cycle, destination written in phase four
// - borrow: result wraps to eight bits, carry and zero cleared, negative is bit seven of the result
// - zero difference: zero and carry set, negative cleared
// - positive difference: carry set, zero cleared, negative is bit seven of the result
package sub_exec_pkg;

  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int BANK_W = 4;
  localparam int FADDR_W = DATA_W + BANK_W;

  // opcode fields
  localparam logic [7:0] LIT_OPC = 8'h08;
  localparam int LIT_OPC_LSB = 8;
  localparam logic [5:0] FILE_OPC = 6'h17;
  localparam int FILE_OPC_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;

  // access bank: low half maps to bank 0, high half to the top bank
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;

  // register map, byte addresses
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] WREG_OFF = 4'h0;
  localparam logic [AXI_AW-1:0] BANKSEL_OFF = 4'h4;
  localparam logic [AXI_AW-1:0] FLAGS_OFF = 4'h8;
  localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
  localparam logic [BANK_W-1:0] BANKSEL_RST = 4'h0;

  // flag positions inside the flag word
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  localparam int FL_W = 5;
  localparam int BUSY_BIT = 8;
  localparam logic [FL_W-1:0] FLAGS_RST = 5'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DEC   = 5'b00010,
    ST_READ  = 5'b00100,
    ST_PROC  = 5'b01000,
    ST_WRITE = 5'b10000
  } phase_t;

  typedef enum logic [2:0] {
    K_NONE = 3'b001,
    K_LIT  = 3'b010,
    K_FILE = 3'b100
  } kind_t;

endpackage

// ### sub_alu.sv
/*
  Eight-bit subtractor with arithmetic flags: minuend minus subtrahend.
  Assumes purely combinational use; the caller registers result and flags.
*/
`timescale 1ns/1ps
`default_nettype none
module sub_alu #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] minu,
  input wire logic [WIDTH-1:0] subt,
  output logic [WIDTH-1:0] diff,
  output logic flag_c,
  output logic flag_dc,
  output logic flag_z,
  output logic flag_ov,
  output logic flag_n
);
  initial begin
    if (WIDTH < 5) $error("sub_alu needs at least five bits");
  end

  always_comb begin
    diff = minu - subt;
    flag_c = (minu >= subt);
    flag_dc = (minu[3:0] >= subt[3:0]);
    flag_z = (diff == '0);
    flag_n = diff[WIDTH-1];
    // signed overflow: operand signs differ and result sign leaves minuend
    flag_ov = (minu[WIDTH-1] != subt[WIDTH-1]) &&
              (diff[WIDTH-1] != minu[WIDTH-1]);
  end
endmodule
`default_nettype wire

// ### sub_exec.sv
/*
  Execution unit for the two subtract instructions, four phases per
  instruction cycle, with an AXI4-Lite slave for the working register,
  bank select register and flags.
  Assumes the decoder, data memory and bus master share CLK; memory read
  data answer the address combinationally within the read phase.
*/
`timescale 1ns/1ps
`default_nettype none
module sub_exec
  import sub_exec_pkg::*;
#(
  parameter logic [sub_exec_pkg::BANK_W-1:0] ACC_HI = sub_exec_pkg::ACC_HI_BANK
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [sub_exec_pkg::INSTR_W-1:0] INSTR,
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  output logic DONE,
  output logic [sub_exec_pkg::FADDR_W-1:0] FILE_ADDR,
  output logic FILE_RD_EN,
  input wire logic [sub_exec_pkg::DATA_W-1:0] FILE_RD_DATA,
  output logic FILE_WR_EN,
  output logic [sub_exec_pkg::DATA_W-1:0] FILE_WR_DATA,
  output logic FLAG_N,
  output logic FLAG_OV,
  output logic FLAG_Z,
  output logic FLAG_DC,
  output logic FLAG_C,
  input wire logic [sub_exec_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [sub_exec_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import sub_exec_pkg::*;

  initial begin
    if (FADDR_W != DATA_W + BANK_W) $error("file address width mismatch");
  end

  function automatic kind_t decode_kind(input logic [INSTR_W-1:0] ins);
    if (ins[INSTR_W-1:LIT_OPC_LSB] == LIT_OPC) return K_LIT;
    if (ins[INSTR_W-1:FILE_OPC_LSB] == FILE_OPC) return K_FILE;
    return K_NONE;
  endfunction

  // bank in front of the 8-bit file field
  function automatic logic [FADDR_W-1:0] resolve_addr(
      input logic [INSTR_W-1:0] ins, input logic [BANK_W-1:0] bsel);
    logic [BANK_W-1:0] bank;
    bank = bsel;
    if (!ins[ACC_BIT]) begin
      bank = (ins[DATA_W-1:0] < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI;
    end
    return {bank, ins[DATA_W-1:0]};
  endfunction

  // execution state
  phase_t state_r, state_nxt;
  kind_t kind_r, kind_nxt;
  logic [INSTR_W-1:0] instr_r, instr_nxt;
  logic [FADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] minu_r, minu_nxt;
  logic [DATA_W-1:0] subt_r, subt_nxt;
  logic [DATA_W-1:0] res_r, res_nxt;
  logic [FL_W-1:0] calc_r, calc_nxt;
  logic [FL_W-1:0] flags_r, flags_nxt;
  logic [DATA_W-1:0] w_r, w_nxt;
  logic [BANK_W-1:0] bsel_r, bsel_nxt;
  logic [DATA_W-1:0] alu_diff;
  logic [FL_W-1:0] alu_fl;
  logic reg_wr;
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [AXI_AW-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  sub_alu #(.WIDTH(DATA_W)) u_alu (
    .minu(minu_r),
    .subt(subt_r),
    .diff(alu_diff),
    .flag_c(alu_fl[FL_C]),
    .flag_dc(alu_fl[FL_DC]),
    .flag_z(alu_fl[FL_Z]),
    .flag_ov(alu_fl[FL_OV]),
    .flag_n(alu_fl[FL_N])
  );

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    minu_nxt = minu_r;
    subt_nxt = subt_r;
    res_nxt = res_r;
    calc_nxt = calc_r;
    flags_nxt = flags_r;
    w_nxt = w_r;
    bsel_nxt = bsel_r;
    // software writes first so a phase-four result wins the same cycle
    if (reg_wr && w_strb_r[0]) begin
      if (aw_addr_r == WREG_OFF) w_nxt = w_data_r[DATA_W-1:0];
      if (aw_addr_r == BANKSEL_OFF) bsel_nxt = w_data_r[BANK_W-1:0];
    end
    unique case (state_r)
      ST_IDLE: begin
        if (INSTR_VALID) begin
          instr_nxt = INSTR;
          state_nxt = ST_DEC;
        end
      end
      ST_DEC: begin
        kind_nxt = decode_kind(instr_r);
        addr_nxt = resolve_addr(instr_r, bsel_r);
        state_nxt = ST_READ;
      end
      ST_READ: begin
        subt_nxt = w_r;
        // literal from the instruction word, else the file register
        minu_nxt = (kind_r == K_LIT) ? instr_r[DATA_W-1:0]
                                     : FILE_RD_DATA;
        state_nxt = ST_PROC;
      end
      ST_PROC: begin
        res_nxt = alu_diff;
        calc_nxt = alu_fl;
        state_nxt = ST_WRITE;
      end
      ST_WRITE: begin
        if (kind_r == K_LIT || (kind_r == K_FILE && !instr_r[DEST_BIT])) begin
          w_nxt = res_r;
        end
        if (kind_r != K_NONE) begin
          flags_nxt = calc_r;
        end
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      kind_r <= K_NONE;
      instr_r <= '0;
      addr_r <= '0;
      minu_r <= '0;
      subt_r <= '0;
      res_r <= '0;
      calc_r <= FLAGS_RST;
      flags_r <= FLAGS_RST;
      w_r <= WREG_RST;
      bsel_r <= BANKSEL_RST;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      instr_r <= instr_nxt;
      addr_r <= addr_nxt;
      minu_r <= minu_nxt;
      subt_r <= subt_nxt;
      res_r <= res_nxt;
      calc_r <= calc_nxt;
      flags_r <= flags_nxt;
      w_r <= w_nxt;
      bsel_r <= bsel_nxt;
    end
  end

  assign INSTR_READY = (state_r == ST_IDLE);
  assign DONE = (state_r == ST_WRITE);
  assign FILE_ADDR = addr_r;
  assign FILE_RD_EN = (state_r == ST_READ) && (kind_r == K_FILE);
  assign FILE_WR_EN = (state_r == ST_WRITE) && (kind_r == K_FILE) &&
                      instr_r[DEST_BIT];
  assign FILE_WR_DATA = res_r;
  assign FLAG_N = flags_r[FL_N];
  assign FLAG_OV = flags_r[FL_OV];
  assign FLAG_Z = flags_r[FL_Z];
  assign FLAG_DC = flags_r[FL_DC];
  assign FLAG_C = flags_r[FL_C];

  // bus slave
  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    return a == WREG_OFF || a == BANKSEL_OFF || a == FLAGS_OFF;
  endfunction
  assign reg_wr = aw_got_r && w_got_r && !bvalid_r;
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_nxt = 1'b1;
      w_data_nxt = S_AXI_WDATA;
      w_strb_nxt = S_AXI_WSTRB;
    end
    if (reg_wr) begin
      // flag word is read-only: write is dropped but still answered okay
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt = '0;
      unique case (S_AXI_ARADDR)
        WREG_OFF: rdata_nxt[DATA_W-1:0] = w_r;
        BANKSEL_OFF: rdata_nxt[BANK_W-1:0] = bsel_r;
        FLAGS_OFF: begin
          rdata_nxt[FL_W-1:0] = flags_r;
          rdata_nxt[BUSY_BIT] = (state_r != ST_IDLE);
        end
        default: rdata_nxt = '0;
      endcase
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign S_AXI_AWREADY = !aw_got_r && !bvalid_r;
  assign S_AXI_WREADY = !w_got_r && !bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  a_phase_order: assert property (
    state_r == ST_DEC |=> state_r == ST_READ ##1 state_r == ST_PROC
      ##1 state_r == ST_WRITE ##1 state_r == ST_IDLE)
    else $error("instruction did not take four phases");
  a_lit_to_w: assert property (
    state_r == ST_WRITE && kind_r == K_LIT && !reg_wr
      |=> w_r == DATA_W'($past(minu_r, 2) - $past(subt_r, 2)))
    else $error("literal difference not in working register");
  a_file_diff: assert property (
    state_r == ST_PROC && kind_r == K_FILE
      |=> res_r == DATA_W'($past(minu_r) - $past(subt_r)))
    else $error("file difference wrong");
  a_dest_w_only: assert property (
    state_r == ST_WRITE && kind_r == K_FILE && !instr_r[DEST_BIT]
      |-> !FILE_WR_EN ##1 w_r == $past(res_r))
    else $error("destination zero mishandled");
  a_dest_file: assert property (
    state_r == ST_WRITE && kind_r == K_FILE && instr_r[DEST_BIT]
      |-> FILE_WR_EN && FILE_WR_DATA == res_r)
    else $error("destination one did not write file");
  a_access_bank: assert property (
    state_r == ST_READ && kind_r == K_FILE && !instr_r[ACC_BIT]
      |-> FILE_ADDR[FADDR_W-1:DATA_W] ==
          ((instr_r[DATA_W-1:0] < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI))
    else $error("access bank not selected");
  a_banked: assert property (
    state_r == ST_DEC && instr_r[ACC_BIT] && decode_kind(instr_r) == K_FILE
      |=> FILE_ADDR == {$past(bsel_r), instr_r[DATA_W-1:0]})
    else $error("bank select not applied");
  a_borrow_flags: assert property (
    state_r == ST_PROC && kind_r != K_NONE && minu_r < subt_r
      |=> ##1 !FLAG_C && !FLAG_Z)
    else $error("borrow flags wrong");
  a_zero_flags: assert property (
    state_r == ST_PROC && kind_r != K_NONE && minu_r == subt_r
      |=> ##1 FLAG_C && FLAG_Z && !FLAG_N)
    else $error("zero flags wrong");
  a_pos_flags: assert property (
    state_r == ST_PROC && kind_r != K_NONE && minu_r > subt_r
      |=> ##1 FLAG_C && !FLAG_Z && FLAG_N == $past(res_r[DATA_W-1]))
    else $error("positive flags wrong");

endmodule
`default_nettype wire

// ### data_mem_model.sv
/*
  Data memory beside the subtract unit: 4096 bytes, read combinationally
  while the read enable is high, written at the edge that ends a write pulse.
  Assumes the unit holds address and write data stable through each pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
  import sub_exec_pkg::*;
(
  input wire logic clk,
  input wire logic [sub_exec_pkg::FADDR_W-1:0] file_addr,
  input wire logic file_rd_en,
  output logic [sub_exec_pkg::DATA_W-1:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [sub_exec_pkg::DATA_W-1:0] file_wr_data
);
  import sub_exec_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<FADDR_W)-1];
  logic [DATA_W-1:0] last_r = 8'hA5;

  // outside the read pulse the bus toggles, so stale data cannot pass
  assign file_rd_data = file_rd_en ? mem[file_addr] : ~last_r;

  // plain always: the bench preloads cells from its own process
  always @(posedge clk) begin
    if (file_rd_en) begin
      last_r <= mem[file_addr];
    end else begin
      last_r <= ~last_r;
    end
    if (file_wr_en) begin
      mem[file_addr] <= file_wr_data;
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
/*
  Self-checking bench for the subtract unit: register access over
  AXI4-Lite, instruction issue, data memory model on the file side.
  Assumes the unit's contract of four cycles from issue to done.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sub_exec_pkg::*;
  logic CLK = 1'h0;
  logic RST = 1'h1;
  logic [INSTR_W-1:0] INSTR = 16'h0000;
  logic INSTR_VALID = 1'h0;
  logic INSTR_READY, DONE, FILE_RD_EN, FILE_WR_EN;
  logic [FADDR_W-1:0] FILE_ADDR;
  logic [DATA_W-1:0] FILE_RD_DATA, FILE_WR_DATA;
  logic FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C;
  logic [AXI_AW-1:0] S_AXI_AWADDR = 4'h0;
  logic [AXI_AW-1:0] S_AXI_ARADDR = 4'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [7:0] e;
  logic [7:0] lit_w [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
  logic [7:0] lit_k [4] = '{8'h02, 8'h02, 8'h02, 8'h80};

  sub_exec uut (.CLK(CLK), .RST(RST), .INSTR(INSTR),
    .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .DONE(DONE),
    .FILE_ADDR(FILE_ADDR), .FILE_RD_EN(FILE_RD_EN),
    .FILE_RD_DATA(FILE_RD_DATA), .FILE_WR_EN(FILE_WR_EN),
    .FILE_WR_DATA(FILE_WR_DATA), .FLAG_N(FLAG_N), .FLAG_OV(FLAG_OV),
    .FLAG_Z(FLAG_Z), .FLAG_DC(FLAG_DC), .FLAG_C(FLAG_C),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY));

  data_mem_model mem_m (.clk(CLK), .file_addr(FILE_ADDR),
    .file_rd_en(FILE_RD_EN), .file_rd_data(FILE_RD_DATA),
    .file_wr_en(FILE_WR_EN), .file_wr_data(FILE_WR_DATA));

  initial begin
    forever #12.5 CLK = ~CLK;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY === 1'h1) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY === 1'h1) S_AXI_WVALID <= 1'h0;
    end while (S_AXI_BVALID !== 1'h1);
    rsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY === 1'h1) S_AXI_ARVALID <= 1'h0;
    end while (S_AXI_RVALID !== 1'h1);
    rd = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
  endtask

  // flags as {N, OV, Z, DC, C} for minuend minus subtrahend
  function automatic logic [4:0] exp_flags(input logic [7:0] m, s);
    logic [7:0] d;
    d = m - s;
    return {d[7], (m[7] != s[7]) && (d[7] != m[7]), d == 8'h00,
      m[3:0] >= s[3:0], m >= s};
  endfunction

  task automatic do_op(input logic [15:0] ins, input logic [7:0] m, s,
      input logic wr, input logic [11:0] a);
    int n;
    n = 0;
    @(posedge CLK);
    INSTR <= ins;
    INSTR_VALID <= 1'h1;
    do @(posedge CLK); while (INSTR_READY !== 1'h1);
    INSTR_VALID <= 1'h0;
    do begin
      @(posedge CLK);
      n++;
    end while (DONE !== 1'h1 && n < 20);
    check(n, 4);
    check(FILE_WR_EN, wr);
    if (ins[15:10] == FILE_OPC) check(FILE_ADDR, a);
    #1;
    check({FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C},
      exp_flags(m, s));
  endtask

  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'h0;
    axi_rd(WREG_OFF);
    check(rd, WREG_RST);
    axi_rd(BANKSEL_OFF);
    check(rd, BANKSEL_RST);
    axi_rd(4'hC);
    check(rsp, RESP_SLVERR);
    check(rd, 32'h0);
    axi_wr(FLAGS_OFF, 32'h1F);
    check(rsp, RESP_OKAY);
    axi_rd(FLAGS_OFF);
    check(rd, 32'h0);
    $display("test registers done");
    // positive, zero, borrow, signed overflow
    for (int i = 0; i < 4; i++) begin
      axi_wr(WREG_OFF, {24'h0, lit_w[i]});
      do_op({LIT_OPC, lit_k[i]}, lit_k[i], lit_w[i], 1'h0,
        12'h0);
      e = lit_k[i] - lit_w[i];
      axi_rd(WREG_OFF);
      check(rd, {24'h0, e});
    end
    axi_rd(FLAGS_OFF);
    check(rd, {27'h0, exp_flags(8'h80, 8'h01)});
    $display("test literal done");
    axi_wr(BANKSEL_OFF, 32'h3);
    axi_wr(WREG_OFF, 32'h2);
    mem_m.mem[12'h310] = 8'h03;
    do_op(16'h5F10, 8'h03, 8'h02, 1'h1, 12'h310);
    check(mem_m.mem[12'h310], 8'h01);
    axi_rd(WREG_OFF);
    check(rd, 32'h2);
    mem_m.mem[{ACC_HI_BANK, 8'h90}] = 8'h02;
    do_op(16'h5C90, 8'h02, 8'h02, 1'h0,
      {ACC_HI_BANK, 8'h90});
    check(mem_m.mem[{ACC_HI_BANK, 8'h90}], 8'h02);
    axi_rd(WREG_OFF);
    check(rd, 32'h0);
    // nonzero working register so the write-back is visible in the cell
    axi_wr(WREG_OFF, 32'h1);
    mem_m.mem[12'h020] = 8'h05;
    do_op(16'h5E20, 8'h05, 8'h01, 1'h1, {ACC_LO_BANK, 8'h20});
    check(mem_m.mem[12'h020], 8'h04);
    // unknown opcode: four phases, flags and working register kept
    do_op(16'h0000, 8'h05, 8'h01, 1'h0, 12'h0);
    axi_rd(WREG_OFF);
    check(rd, 32'h1);
    $display("test file done");
    print_verdict();
  end
endmodule
`default_nettype wire
